/* File: hdl/intr_pkg.sv */
// Purpose: shared constants and carriers for the interrupt status and mask block
// Assumes: 32-bit register bus with single-cycle read and write strobes
// Notes:   flag positions follow the unmasked event flag register
package intr_pkg;
  localparam logic [7:0]  OFF_MASK       = 8'h30;
  localparam logic [7:0]  OFF_RAW        = 8'h34;
  localparam logic [7:0]  OFF_MASKED     = 8'h2C;
  localparam logic [7:0]  OFF_CLR_ALL    = 8'h40;
  localparam logic [7:0]  OFF_CLR_RXUND  = 8'h44;
  localparam logic [7:0]  OFF_CLR_RXOVR  = 8'h48;
  localparam logic [7:0]  OFF_CLR_TXOVR  = 8'h4C;
  localparam logic [7:0]  OFF_CLR_RDREQ  = 8'h50;
  localparam logic [7:0]  OFF_CLR_ABRT   = 8'h54;
  localparam logic [7:0]  OFF_CLR_DONE   = 8'h58;
  localparam logic [7:0]  OFF_CLR_ACT    = 8'h5C;
  localparam logic [7:0]  OFF_CLR_STOP   = 8'h60;
  localparam logic [7:0]  OFF_CLR_START  = 8'h64;
  localparam logic [7:0]  OFF_CLR_GCALL  = 8'h68;

  localparam int          NUM_FLAGS      = 12;
  localparam int          B_RX_UNDER     = 0;
  localparam int          B_RX_OVER      = 1;
  localparam int          B_RX_FULL      = 2;
  localparam int          B_TX_OVER      = 3;
  localparam int          B_TX_EMPTY     = 4;
  localparam int          B_RD_REQ       = 5;
  localparam int          B_TX_ABRT      = 6;
  localparam int          B_RX_DONE      = 7;
  localparam int          B_ACTIVITY     = 8;
  localparam int          B_STOP_DET     = 9;
  localparam int          B_START_DET    = 10;
  localparam int          B_GEN_CALL     = 11;

  localparam logic [11:0] MASK_RESET     = 12'h8FF;
  localparam logic [11:0] FLAGS_RESET    = 12'h000;
  // flags cleared only by hardware level conditions
  localparam logic [11:0] HW_CLEAR_SET   = 12'h014;
  localparam logic [31:0] ABORT_RESET    = 32'h0000_0000;

  typedef struct packed {
    logic        start_det;
    logic        stop_det;
    logic        gen_call_ack;
    logic        slave_tx_nack;
    logic        tx_abort;
    logic [31:0] abort_reason;
    logic        rx_byte_in;
    logic        rx_fifo_full;
    logic        rx_at_thresh;
    logic        tx_at_thresh;
    logic        tx_fifo_full;
    logic        rd_req_addr;
    logic        fsm_active;
  } bus_events_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage : intr_pkg

/* File: hdl/intr_flag_bit.sv */
// Purpose: one sticky event flag with set priority over clear
// Assumes: set, clear and hold inputs are synchronous to clk_i
// Notes:   hold forces the flag low while asserted
module intr_flag_bit (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic hold_i,
  output logic      flag_o
);
  typedef struct packed {
    logic flag;
  } flag_state_t;

  flag_state_t state;
  flag_state_t next_state;

  always_comb begin
    next_state = state;
    if (hold_i) begin
      next_state.flag = 1'b0;
    end else if (set_i) begin
      next_state.flag = 1'b1;
    end else if (clr_i) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag_o = state.flag;
endmodule : intr_flag_bit

/* File: hdl/intr_status_mask.sv */
// Purpose: raw event flags, mask and masked status of a two-wire bus controller
// Assumes: bus event strobes come from logic on clk_i; reads return data next cycle
// Notes:   reading a clear register returns its flag state before clearing
module intr_status_mask (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 reg_rd_i,
  input  wire logic                 reg_wr_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 data_cmd_wr_i,
  input  wire logic                 data_cmd_rd_i,
  input  wire logic                 rx_fifo_empty_i,
  input  wire logic                 controller_enable_i,
  input  wire intr_pkg::bus_events_t ev_i,
  output logic [31:0]               reg_rdata_o,
  output logic                      reg_rvalid_o,
  output logic                      intr_o,
  output logic                      tx_fifo_flush_o,
  output logic                      rx_fifo_flush_o,
  output logic                      scl_hold_low_o,
  output logic                      internal_enable_state_o,
  output logic [31:0]               abort_reason_record_o
);
  typedef struct packed {
    logic [11:0] interrupt_enable_mask;
    logic [31:0] abort_reason_record;
    logic        internal_enable_state;
    logic        tx_empty;
    logic        rx_full;
    logic [31:0] rdata;
    logic        rvalid;
    logic        intr;
    logic        tx_flush;
    logic        rx_flush;
    logic        scl_hold;
  } top_state_t;

  top_state_t  state;
  top_state_t  next_state;
  logic [11:0] sticky;
  logic [11:0] set_vec;
  logic [11:0] clr_vec;
  logic [11:0] hold_vec;
  logic [11:0] unmasked_event_flags;
  logic [11:0] masked_event_flags;
  logic        rd_clr_all;

  function automatic logic rd_hit(input logic [7:0] a, input logic [7:0] off);
    rd_hit = reg_rd_i && (a == off);
  endfunction : rd_hit

  assign rd_clr_all = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_ALL);

  always_comb begin
    set_vec  = '0;
    clr_vec  = '0;
    hold_vec = '0;
    set_vec[intr_pkg::B_GEN_CALL]  = ev_i.gen_call_ack;
    set_vec[intr_pkg::B_START_DET] = ev_i.start_det;
    set_vec[intr_pkg::B_STOP_DET]  = ev_i.stop_det;
    set_vec[intr_pkg::B_ACTIVITY]  = ev_i.fsm_active;
    set_vec[intr_pkg::B_RX_DONE]   = ev_i.slave_tx_nack;
    set_vec[intr_pkg::B_TX_ABRT]   = ev_i.tx_abort;
    set_vec[intr_pkg::B_RD_REQ]    = ev_i.rd_req_addr;
    set_vec[intr_pkg::B_TX_OVER]   = data_cmd_wr_i && ev_i.tx_fifo_full;
    set_vec[intr_pkg::B_RX_OVER]   = ev_i.rx_byte_in && ev_i.rx_fifo_full;
    set_vec[intr_pkg::B_RX_UNDER]  = data_cmd_rd_i && rx_fifo_empty_i;
    clr_vec[intr_pkg::B_GEN_CALL]  = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_GCALL);
    clr_vec[intr_pkg::B_START_DET] = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_START);
    clr_vec[intr_pkg::B_STOP_DET]  = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_STOP);
    clr_vec[intr_pkg::B_ACTIVITY]  = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_ACT);
    clr_vec[intr_pkg::B_RX_DONE]   = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_DONE);
    clr_vec[intr_pkg::B_TX_ABRT]   = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_ABRT);
    clr_vec[intr_pkg::B_RD_REQ]    = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_RDREQ);
    clr_vec[intr_pkg::B_TX_OVER]   = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_TXOVR);
    clr_vec[intr_pkg::B_RX_OVER]   = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_RXOVR);
    clr_vec[intr_pkg::B_RX_UNDER]  = rd_hit(reg_addr_i, intr_pkg::OFF_CLR_RXUND);
    clr_vec = clr_vec | ({12{rd_clr_all}} & ~intr_pkg::HW_CLEAR_SET);
    // disable clears broadcast at once, activity once the state machines are idle, overflow and underflow flags when internal enable drops
    hold_vec[intr_pkg::B_GEN_CALL] = !controller_enable_i;
    hold_vec[intr_pkg::B_ACTIVITY] = !controller_enable_i && !ev_i.fsm_active;
    hold_vec[intr_pkg::B_TX_OVER]  = !state.internal_enable_state;
    hold_vec[intr_pkg::B_RX_OVER]  = !state.internal_enable_state;
    hold_vec[intr_pkg::B_RX_UNDER] = !state.internal_enable_state;
  end

  genvar gi;
  generate
    for (gi = 0; gi < intr_pkg::NUM_FLAGS; gi++) begin : g_flag
      if (((intr_pkg::HW_CLEAR_SET >> gi) & 12'h001) != 12'h000) begin : g_hw
        assign sticky[gi] = 1'b0;
      end else begin : g_sw
        intr_flag_bit u_flag (
          .clk_i     (clk_i),
          .sys_rst_i (sys_rst_i),
          .set_i     (set_vec[gi]),
          .clr_i     (clr_vec[gi]),
          .hold_i    (hold_vec[gi]),
          .flag_o    (sticky[gi])
        );
      end
    end
  endgenerate

  always_comb begin
    unmasked_event_flags = sticky;
    unmasked_event_flags[intr_pkg::B_TX_EMPTY] = state.tx_empty;
    unmasked_event_flags[intr_pkg::B_RX_FULL]  = state.rx_full;
    masked_event_flags = unmasked_event_flags & state.interrupt_enable_mask;
  end

  always_comb begin
    next_state = state;
    next_state.rvalid = reg_rd_i;
    next_state.rdata  = '0;
    // internal enable drops only once the state machines are idle
    if (controller_enable_i) begin
      next_state.internal_enable_state = 1'b1;
    end else if (!ev_i.fsm_active) begin
      next_state.internal_enable_state = 1'b0;
    end
    if (controller_enable_i) begin
      next_state.tx_empty = ev_i.tx_at_thresh || state.tx_flush;
    end else begin
      next_state.tx_empty = ev_i.fsm_active;
    end
    next_state.rx_full = controller_enable_i && ev_i.rx_at_thresh;
    if (reg_wr_i && reg_addr_i == intr_pkg::OFF_MASK) begin
      next_state.interrupt_enable_mask = reg_wdata_i[11:0];
    end
    if (ev_i.tx_abort) begin
      next_state.abort_reason_record = ev_i.abort_reason;
    end else if (rd_clr_all || clr_vec[intr_pkg::B_TX_ABRT]) begin
      next_state.abort_reason_record = intr_pkg::ABORT_RESET;
    end
    next_state.tx_flush = !controller_enable_i || set_vec[intr_pkg::B_TX_ABRT]
                        || (sticky[intr_pkg::B_TX_ABRT] && !clr_vec[intr_pkg::B_TX_ABRT]);
    next_state.rx_flush = !controller_enable_i;
    next_state.scl_hold = set_vec[intr_pkg::B_RD_REQ]
                        || (sticky[intr_pkg::B_RD_REQ] && !clr_vec[intr_pkg::B_RD_REQ]);
    next_state.intr = |masked_event_flags;
    if (reg_rd_i) begin
      case (reg_addr_i)
        intr_pkg::OFF_MASK:      next_state.rdata = {20'h00000, state.interrupt_enable_mask};
        intr_pkg::OFF_RAW:       next_state.rdata = {20'h00000, unmasked_event_flags};
        intr_pkg::OFF_MASKED:    next_state.rdata = {20'h00000, masked_event_flags};
        intr_pkg::OFF_CLR_ALL:   next_state.rdata = {31'h0, |masked_event_flags};
        intr_pkg::OFF_CLR_RXUND: next_state.rdata = {31'h0, sticky[intr_pkg::B_RX_UNDER]};
        intr_pkg::OFF_CLR_RXOVR: next_state.rdata = {31'h0, sticky[intr_pkg::B_RX_OVER]};
        intr_pkg::OFF_CLR_TXOVR: next_state.rdata = {31'h0, sticky[intr_pkg::B_TX_OVER]};
        intr_pkg::OFF_CLR_RDREQ: next_state.rdata = {31'h0, sticky[intr_pkg::B_RD_REQ]};
        intr_pkg::OFF_CLR_ABRT:  next_state.rdata = {31'h0, sticky[intr_pkg::B_TX_ABRT]};
        intr_pkg::OFF_CLR_DONE:  next_state.rdata = {31'h0, sticky[intr_pkg::B_RX_DONE]};
        intr_pkg::OFF_CLR_ACT:   next_state.rdata = {31'h0, sticky[intr_pkg::B_ACTIVITY]};
        intr_pkg::OFF_CLR_STOP:  next_state.rdata = {31'h0, sticky[intr_pkg::B_STOP_DET]};
        intr_pkg::OFF_CLR_START: next_state.rdata = {31'h0, sticky[intr_pkg::B_START_DET]};
        intr_pkg::OFF_CLR_GCALL: next_state.rdata = {31'h0, sticky[intr_pkg::B_GEN_CALL]};
        default:                 next_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state                       <= '0;
      state.interrupt_enable_mask <= intr_pkg::MASK_RESET;
      state.abort_reason_record   <= intr_pkg::ABORT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o             = state.rdata;
  assign reg_rvalid_o            = state.rvalid;
  assign intr_o                  = state.intr;
  assign tx_fifo_flush_o         = state.tx_flush;
  assign rx_fifo_flush_o         = state.rx_flush;
  assign scl_hold_low_o          = state.scl_hold;
  assign internal_enable_state_o = state.internal_enable_state;
  assign abort_reason_record_o   = state.abort_reason_record;

  masked_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !state.interrupt_enable_mask[intr_pkg::B_START_DET] |-> !masked_event_flags[intr_pkg::B_START_DET])
    else $error("masked start flag passed a zero mask");
  raw_shows_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev_i.start_det |=> unmasked_event_flags[intr_pkg::B_START_DET])
    else $error("raw start flag missed its event");
  gcall_disable_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !controller_enable_i |=> !unmasked_event_flags[intr_pkg::B_GEN_CALL])
    else $error("broadcast flag survived disable");
  stop_sets_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev_i.stop_det |=> unmasked_event_flags[intr_pkg::B_STOP_DET])
    else $error("stop flag missed its event");
  act_sticky_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (sticky[intr_pkg::B_ACTIVITY] && controller_enable_i && !clr_vec[intr_pkg::B_ACTIVITY])
    |=> sticky[intr_pkg::B_ACTIVITY])
    else $error("activity flag dropped without clear");
  abort_flush_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev_i.tx_abort |=> tx_fifo_flush_o ##1 (tx_fifo_flush_o || !sticky[intr_pkg::B_TX_ABRT]))
    else $error("transmit fifo not flushed on abort");
  rdreq_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ev_i.rd_req_addr |=> scl_hold_low_o)
    else $error("clock not held on read request");
  rxfull_dis_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(controller_enable_i) |=> !unmasked_event_flags[intr_pkg::B_RX_FULL])
    else $error("rx threshold flag not cleared on disable");
  underflow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (data_cmd_rd_i && rx_fifo_empty_i && state.internal_enable_state && controller_enable_i)
    |=> unmasked_event_flags[intr_pkg::B_RX_UNDER])
    else $error("underflow flag missed empty read");
  intr_or_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    intr_o == $past(|masked_event_flags))
    else $error("interrupt not or of masked flags");
endmodule : intr_status_mask

/* File: test/bus_side_model.sv */
// Purpose: far-side bus agent giving event strobes and levels to the flag block
// Assumes: tasks are called from the bench in the clk_i domain
// Notes:   strobes last one clock; reason is dropped with its strobe
module bus_side_model (
  input  wire logic             clk_i,
  output intr_pkg::bus_events_t ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // level fields kept when strobes drop
  localparam logic [43:0] KEEP = 44'h000_0000_003D;
  initial ev_o = '0;
  // 0 gen call, 1 start, 2 stop, 3 nack, 4 read request, 5 abort, 6 rx byte
  task automatic pulse(input int k, input logic [31:0] why);
    @(posedge clk_i);
    case (k)
      0: ev_o.gen_call_ack <= 1'b1;
      1: ev_o.start_det <= 1'b1;
      2: ev_o.stop_det <= 1'b1;
      3: ev_o.slave_tx_nack <= 1'b1;
      4: ev_o.rd_req_addr <= 1'b1;
      5: ev_o.tx_abort <= 1'b1;
      default: ev_o.rx_byte_in <= 1'b1;
    endcase
    ev_o.abort_reason <= why;
    @(posedge clk_i);
    ev_o <= intr_pkg::bus_events_t'(ev_o & KEEP);
  endtask : pulse
  // rx full, rx threshold, tx threshold, tx full, state machine active
  task automatic levels(input logic [4:0] v);
    @(posedge clk_i);
    {ev_o.rx_fifo_full, ev_o.rx_at_thresh, ev_o.tx_at_thresh, ev_o.tx_fifo_full,
     ev_o.fsm_active} <= v;
  endtask : levels
endmodule : bus_side_model

/* File: test/intr_status_mask_bench.sv */
// Purpose: self-checking bench for the interrupt status and mask block
// Assumes: reads answer one clock after the strobe
// Notes:   far-side events come from bus_side_model
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module intr_status_mask_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, reg_rd_i = 1'b0, reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, abort_reason_record_o, d;
  logic data_cmd_wr_i = 1'b0, data_cmd_rd_i = 1'b0, rx_fifo_empty_i = 1'b0;
  logic controller_enable_i = 1'b1, reg_rvalid_o, intr_o, tx_fifo_flush_o;
  logic rx_fifo_flush_o, scl_hold_low_o, internal_enable_state_o;
  intr_pkg::bus_events_t ev_i;
  int error_cnt = 0, cmp_count = 0;
  int bit_of[5] = '{11, 10, 9, 7, 5};
  logic [7:0] clr_of[5] = '{8'h68, 8'h64, 8'h60, 8'h58, 8'h50};
  always #10 clk_i = ~clk_i;
  bus_side_model i_bus_side_model (.clk_i, .ev_o(ev_i));
  intr_status_mask i_intr_status_mask (.clk_i, .sys_rst_i, .reg_rd_i, .reg_wr_i,
    .reg_addr_i, .reg_wdata_i, .data_cmd_wr_i, .data_cmd_rd_i, .rx_fifo_empty_i,
    .controller_enable_i, .ev_i, .reg_rdata_o, .reg_rvalid_o, .intr_o,
    .tx_fifo_flush_o, .rx_fifo_flush_o, .scl_hold_low_o, .internal_enable_state_o,
    .abort_reason_record_o);
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, reg_rvalid_o)
    q = reg_rdata_o;
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    rd(a, q);
    `CHK(nm, e, q)
  endtask : rdchk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic dcmd(input logic w, input logic r);
    @(posedge clk_i);
    data_cmd_wr_i <= w;
    data_cmd_rd_i <= r;
    @(posedge clk_i);
    data_cmd_wr_i <= 1'b0;
    data_cmd_rd_i <= 1'b0;
  endtask : dcmd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdchk(8'h30, 32'h0000_08FF, "mask reset");
    wr(8'h34, 32'h0000_0FFF);
    rdchk(8'h34, 32'h0, "raw reset");
    rdchk(8'h00, 32'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      i_bus_side_model.pulse(i, 32'h0);
      rdchk(8'h34, 32'h1 << bit_of[i], "raw flag");
      rdchk(8'h2C, (32'h1 << bit_of[i]) & 32'h8FF, "masked flag");
      `CHK("interrupt", |((32'h1 << bit_of[i]) & 32'h8FF), intr_o)
      if (i == 4) begin
        `CHK("clock hold", 1'b1, scl_hold_low_o)
        dcmd(1'b1, 1'b0);
      end
      rdchk(clr_of[i], 32'h1, "clear read");
      rdchk(8'h34, 32'h0, "raw cleared");
      `CHK("clock hold", 1'b0, scl_hold_low_o)
    end
    $display("test sticky done");
    i_bus_side_model.pulse(5, 32'h0000_0A5A);
    rdchk(8'h34, 32'h50, "abort flag");
    `CHK("abort record", 32'h0000_0A5A, abort_reason_record_o)
    `CHK("tx flush", 1'b1, tx_fifo_flush_o)
    rdchk(8'h54, 32'h1, "abort clear");
    tick(1);
    `CHK("tx flush", 1'b0, tx_fifo_flush_o)
    rdchk(8'h34, 32'h0, "abort cleared");
    $display("test abort done");
    i_bus_side_model.levels(5'b11110);
    rx_fifo_empty_i <= 1'b1;
    dcmd(1'b1, 1'b1);
    i_bus_side_model.pulse(6, 32'h0);
    i_bus_side_model.pulse(5, 32'h0000_0123);
    rdchk(8'h34, 32'h5F, "overflow flags");
    `CHK("interrupt", 1'b1, intr_o)
    rd(8'h40, d);
    rdchk(8'h34, 32'h14, "after combined");
    `CHK("abort record", 32'h0, abort_reason_record_o)
    i_bus_side_model.levels(5'b00000);
    rx_fifo_empty_i <= 1'b0;
    rdchk(8'h34, 32'h0, "levels low");
    tick(2);
    `CHK("interrupt", 1'b0, intr_o)
    $display("test overflow done");
    wr(8'h30, 32'hFFFF_F200);
    rdchk(8'h30, 32'h200, "mask write");
    i_bus_side_model.pulse(2, 32'h0);
    tick(2);
    `CHK("interrupt", 1'b1, intr_o)
    wr(8'h30, 32'h0);
    rdchk(8'h2C, 32'h0, "masked off");
    rdchk(8'h34, 32'h200, "raw unmasked");
    `CHK("interrupt", 1'b0, intr_o)
    rdchk(8'h60, 32'h1, "stop clear");
    wr(8'h30, 32'h8FF);
    $display("test mask done");
    i_bus_side_model.levels(5'b01011);
    dcmd(1'b1, 1'b0);
    rdchk(8'h34, 32'h10C, "activity");
    controller_enable_i <= 1'b0;
    tick(3);
    rdchk(8'h34, 32'h118, "disabled busy");
    `CHK("rx flush", 1'b1, rx_fifo_flush_o)
    `CHK("internal enable", 1'b1, internal_enable_state_o)
    i_bus_side_model.levels(5'b01000);
    tick(3);
    rdchk(8'h34, 32'h0, "disabled idle");
    `CHK("internal enable", 1'b0, internal_enable_state_o)
    `CHK("tx flush", 1'b1, tx_fifo_flush_o)
    $display("test disable done");
    wrap_up();
  end
endmodule : intr_status_mask_bench
